/* File: ascii_pkg.sv */
// shared constants for the ascii module status and init check
package ascii_pkg;
    localparam int WORD_W = 16;
    localparam int IBUF_DEPTH = 8;
    localparam int IBUF_AW = 3;
    // config word first fields
    localparam int CFG1_OPMODE_LSB = 2;
    localparam int CFG1_TXMODE_LSB = 5;
    localparam int CFG1_PARITY_LSB = 12;
    localparam logic [2:0] OPMODE_MAX = 3'h1;
    localparam logic [2:0] TXMODE_MAX = 3'h5;
    localparam logic [2:0] TXMODE_SIMPLEX_WR = 3'h2;
    // config word second fields
    localparam int CFG2_MULTI_BIT = 15;
    // delimiter field of config words three and four
    localparam int DELIM_LSB = 8;
    localparam int DELIM_W = 7;
    localparam logic [6:0] DELIM_FOURTH_DEFAULT = 7'h3a;
    localparam logic [6:0] DELIM_NONE = 7'h00;
    // status word first bit positions
    localparam int SW1_CHAN_ACTIVE = 15;
    localparam int SW1_INIT_ERR = 10;
    localparam int SW1_IBUF_FULL = 3;
    localparam int SW1_IBUF_75 = 2;
    localparam int SW1_IBUF_50 = 1;
    localparam int SW1_IBUF_EMPTY = 0;
    // control word first bit positions
    localparam int CW1_IBUF_CLR = 3;
    // controller register byte offsets
    localparam logic [7:0] OFS_CFG1 = 8'h00;
    localparam logic [7:0] OFS_CFG2 = 8'h04;
    localparam logic [7:0] OFS_CFG3 = 8'h08;
    localparam logic [7:0] OFS_CFG4 = 8'h0c;
    localparam logic [7:0] OFS_INIT_GO = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATUS1 = 8'h18;
    localparam logic [7:0] OFS_STATUS2 = 8'h1c;
    localparam logic [7:0] OFS_RXDATA = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFS_IRQ_EN = 8'h2c;
    localparam int IRQ_W = 3;
    localparam int IRQ_INIT_ERR = 0;
    localparam int IRQ_IBUF_FULL = 1;
    localparam int IRQ_CHAR = 2;
    localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

/* File: ascii_link_if.sv */
// link between the controller end and the ascii device end
`timescale 1ns/100ps
interface ascii_link_if (
    input wire logic clk_sys,
    input wire logic arst_n
);
    logic init_valid;
    logic [2:0] init_count;
    logic [15:0] cfg_word [4];
    logic [15:0] control_word_first;
    logic char_take;
    logic char_valid;
    logic [7:0] char_data;
    logic [15:0] status_word_first;
    logic [15:0] string_count_status;

    modport dev (
        input init_valid, init_count, cfg_word, control_word_first, char_take,
        output char_valid, char_data, status_word_first, string_count_status
    );
    modport ctl (
        output init_valid, init_count, cfg_word, control_word_first, char_take,
        input char_valid, char_data, status_word_first, string_count_status
    );
endinterface // ascii_link_if

/* File: ascii_dev_end.sv */
// ascii device end: init check, status words, indicators, input buffer
`timescale 1ns/100ps
// Summary of operation
// R1: strings per transfer as BCD, upper byte
// R2: words per string as BCD, low byte
// R3: bad init field flags error, stops operation
// R4: op mode above 1, tx mode above 5
// R5: string end equals fourth delimiter is error
// R6: fourth unused: string end 3A is error
// R7: all four used: delimiter 00 is error
// R8: init error shows status word X4XX
// R9: parity from first config word bits 12,13
// R10: fault indicator only on hardware fault
// R11: buffer full lit until control clear
// R12: channel active from receive line only
// R13: simplex write ignores receive line
// R14: control lines: full buffer stops sender
// R15: no control lines: full buffer drops characters
// R16: status bit 10 marks init error
// R17: status bit 3 full, control clears when empty
// R18: check every init, hold error until valid
module ascii_dev_end (
    input wire logic clk_sys,
    input wire logic arst_n,
    ascii_link_if.dev link,
    input wire logic rxd_pin,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic use_ctrl_lines,
    input wire logic hw_fault,
    input wire logic [6:0] strings_per_xfer,
    input wire logic [6:0] words_per_string,
    output logic stop_send,
    output logic [1:0] parity_sel,
    output logic char_dropped,
    output logic led_fault,
    output logic led_buffer_full,
    output logic led_channel_active
);
    // binary 0..99 to two BCD digits
    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        logic [6:0] tens;
        logic [6:0] ones;
        tens = 7'(v / 7'd10);
        ones = 7'(v - 7'(tens * 7'd10));
        return {tens[3:0], ones[3:0]};
    endfunction

    // true if any nibble of a string length is not BCD
    function automatic logic non_bcd(input logic [13:0] v);
        return (v[3:0] > 4'h9) || (v[7:4] > 4'h9) || (v[11:8] > 4'h9);
    endfunction

    logic rxd_meta_r;
    logic rxd_sync_r;
    logic init_err_r;
    logic [15:0] cfg1_r;
    logic [15:0] cfg2_r;
    logic ibuf_full_r;
    logic chan_active_r;
    logic stop_send_r;
    logic dropped_r;
    logic fault_r;
    logic [7:0] mem_r [ascii_pkg::IBUF_DEPTH];
    logic [ascii_pkg::IBUF_AW-1:0] wptr_r;
    logic [ascii_pkg::IBUF_AW-1:0] rptr_r;
    logic [ascii_pkg::IBUF_AW:0] count_r;
    logic [ascii_pkg::IBUF_AW:0] count_nxt;
    logic [15:0] sw1_r;
    logic [15:0] sw2_r;

    localparam int IBUF_DEPTH = ascii_pkg::IBUF_DEPTH;
    localparam logic [ascii_pkg::IBUF_AW:0] CNT_FULL = (ascii_pkg::IBUF_AW+1)'(ascii_pkg::IBUF_DEPTH);
    localparam logic [ascii_pkg::IBUF_AW:0] CNT_HALF = (ascii_pkg::IBUF_AW+1)'(ascii_pkg::IBUF_DEPTH / 2);
    localparam logic [ascii_pkg::IBUF_AW:0] CNT_75 = (ascii_pkg::IBUF_AW+1)'(ascii_pkg::IBUF_DEPTH * 3 / 4);

    // init field decode
    wire [15:0] w1 = link.cfg_word[0];
    wire [15:0] w2 = link.cfg_word[1];
    wire [15:0] w3 = link.cfg_word[2];
    wire [15:0] w4 = link.cfg_word[3];
    wire [2:0] opmode = w1[ascii_pkg::CFG1_OPMODE_LSB +: 3];
    wire [2:0] txmode = w1[ascii_pkg::CFG1_TXMODE_LSB +: 3];
    wire use_w2 = link.init_count >= 3'd2;
    wire use_w3 = link.init_count >= 3'd3;
    wire use_w4 = link.init_count >= 3'd4;
    wire [6:0] eos_delim = use_w3 ? w3[ascii_pkg::DELIM_LSB +: ascii_pkg::DELIM_W] : ascii_pkg::DELIM_NONE;
    wire [6:0] fill_delim = w4[ascii_pkg::DELIM_LSB +: ascii_pkg::DELIM_W];
    // R4: mode ranges
    wire bad_mode = (opmode > ascii_pkg::OPMODE_MAX) || (txmode > ascii_pkg::TXMODE_MAX);
    // R5: delimiters equal
    wire bad_same = use_w3 && use_w4 && (eos_delim == fill_delim);
    // R6: default colon clash
    wire bad_colon = !use_w4 && (eos_delim == ascii_pkg::DELIM_FOURTH_DEFAULT);
    // R7: zero delimiter
    wire bad_zero = use_w4 && (fill_delim == ascii_pkg::DELIM_NONE);
    wire bad_len = use_w2 && non_bcd(w2[13:0]);
    // R3: any bad field
    wire init_bad = bad_mode || bad_same || bad_colon || bad_zero || bad_len;

    // buffer traffic; error stops all storage
    wire cur_simplex_wr = cfg1_r[ascii_pkg::CFG1_TXMODE_LSB +: 3] == ascii_pkg::TXMODE_SIMPLEX_WR;
    wire buf_full = count_r == CNT_FULL;
    wire buf_empty = count_r == '0;
    wire rx_ok = rx_char_valid && !init_err_r && !cur_simplex_wr;
    // R15: full drops
    wire push = rx_ok && !buf_full;
    wire drop = rx_ok && buf_full;
    wire pop = link.char_take && !buf_empty;
    // R17: clear only when empty
    wire full_clr = link.control_word_first[ascii_pkg::CW1_IBUF_CLR] && buf_empty;
    wire multi = cfg2_r[ascii_pkg::CFG2_MULTI_BIT];

    assign count_nxt = count_r + (ascii_pkg::IBUF_AW+1)'(push) - (ascii_pkg::IBUF_AW+1)'(pop);

    // receive line synchroniser
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rxd_meta_r <= 1'b0;
            rxd_sync_r <= 1'b0;
        end else begin
            rxd_meta_r <= rxd_pin;
            rxd_sync_r <= rxd_meta_r;
        end
    end

    // R18: check each init
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_err_r <= 1'b0;
            cfg1_r <= ascii_pkg::RST_WORD;
            cfg2_r <= ascii_pkg::RST_WORD;
        end else if (link.init_valid) begin
            init_err_r <= init_bad;
            cfg1_r <= w1;
            cfg2_r <= use_w2 ? w2 : ascii_pkg::RST_WORD;
        end
    end

    // input buffer storage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wptr_r] <= rx_char;
        end
    end

    // R11: sticky full flag
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ibuf_full_r <= 1'b0;
        end else if (count_nxt == CNT_FULL) begin
            ibuf_full_r <= 1'b1;
        end else if (full_clr) begin
            ibuf_full_r <= 1'b0;
        end
    end

    // indicators and line control
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chan_active_r <= 1'b0;
            stop_send_r <= 1'b0;
            dropped_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            // R12: receive line only
            // R13: simplex write masked
            chan_active_r <= rxd_sync_r && !cur_simplex_wr;
            // R14: hold off sender
            stop_send_r <= use_ctrl_lines && (count_nxt == CNT_FULL);
            dropped_r <= drop;
            // R10: hardware fault only
            fault_r <= hw_fault;
        end
    end

    // status words
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sw1_r <= ascii_pkg::RST_WORD;
            sw2_r <= ascii_pkg::RST_WORD;
        end else begin
            sw1_r <= ascii_pkg::RST_WORD;
            sw1_r[ascii_pkg::SW1_CHAN_ACTIVE] <= chan_active_r;
            // R16: init error bit
            // R8: reads X4XX
            sw1_r[ascii_pkg::SW1_INIT_ERR] <= init_err_r;
            // R17: full status bit
            sw1_r[ascii_pkg::SW1_IBUF_FULL] <= ibuf_full_r;
            sw1_r[ascii_pkg::SW1_IBUF_75] <= count_r >= CNT_75;
            sw1_r[ascii_pkg::SW1_IBUF_50] <= count_r >= CNT_HALF;
            sw1_r[ascii_pkg::SW1_IBUF_EMPTY] <= buf_empty;
            // R1: strings BCD
            sw2_r[15:8] <= multi ? to_bcd(strings_per_xfer) : 8'h00;
            // R2: words BCD
            sw2_r[7:0] <= to_bcd(words_per_string);
        end
    end

    assign link.char_valid = !buf_empty;
    assign link.char_data = mem_r[rptr_r];
    assign link.status_word_first = sw1_r;
    assign link.string_count_status = sw2_r;
    assign stop_send = stop_send_r;
    // R9: parity select
    assign parity_sel = cfg1_r[ascii_pkg::CFG1_PARITY_LSB +: 2];
    assign char_dropped = dropped_r;
    assign led_fault = fault_r;
    assign led_buffer_full = ibuf_full_r;
    assign led_channel_active = chan_active_r;
endmodule // ascii_dev_end

/* File: ascii_ctl_end.sv */
// controller end: apb registers, init transfer, status and interrupts
`timescale 1ns/100ps
module ascii_ctl_end (
    input wire logic clk_sys,
    input wire logic arst_n,
    ascii_link_if.ctl link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq
);
    logic [15:0] cfg_r [4];
    logic [2:0] count_r;
    logic init_valid_r;
    logic [15:0] ctrl_r;
    logic take_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [ascii_pkg::IRQ_W-1:0] irq_stat_r;
    logic [ascii_pkg::IRQ_W-1:0] irq_en_r;
    logic irq_r;
    logic err_d_r;
    logic full_d_r;
    logic char_d_r;

    wire access = psel && penable && !pready_r;
    // writes land at the completing edge, with pready high
    wire wr = psel && penable && pready_r && pwrite;
    wire rd = access && !pwrite;
    wire is_cfg = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
    wire [1:0] cfg_idx = paddr[3:2];
    wire [31:0] init_rd = {29'h0000_0000, count_r};
    wire [31:0] irq_rd = {29'h0000_0000, irq_stat_r};
    wire [31:0] en_rd = {29'h0000_0000, irq_en_r};
    wire [31:0] rx_rd = {23'h00_0000, link.char_valid, link.char_data};
    wire [31:0] sw1_rd = {16'h0000, link.status_word_first};
    wire [31:0] sw2_rd = {16'h0000, link.string_count_status};
    wire [31:0] cfg_rd = {16'h0000, cfg_r[cfg_idx]};
    wire [31:0] ctrl_rd = {16'h0000, ctrl_r};

    logic [31:0] rd_val;
    logic mapped;
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        if (is_cfg) begin
            rd_val = cfg_rd;
        end else if (paddr == ascii_pkg::OFS_INIT_GO) begin
            rd_val = init_rd;
        end else if (paddr == ascii_pkg::OFS_CTRL) begin
            rd_val = ctrl_rd;
        end else if (paddr == ascii_pkg::OFS_STATUS1) begin
            rd_val = sw1_rd;
        end else if (paddr == ascii_pkg::OFS_STATUS2) begin
            rd_val = sw2_rd;
        end else if (paddr == ascii_pkg::OFS_RXDATA) begin
            rd_val = rx_rd;
        end else if (paddr == ascii_pkg::OFS_IRQ_STAT) begin
            rd_val = irq_rd;
        end else if (paddr == ascii_pkg::OFS_IRQ_CLR) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == ascii_pkg::OFS_IRQ_EN) begin
            rd_val = en_rd;
        end else begin
            mapped = 1'b0;
        end
    end

    wire ro_hit = (paddr == ascii_pkg::OFS_STATUS1) || (paddr == ascii_pkg::OFS_STATUS2)
        || (paddr == ascii_pkg::OFS_RXDATA) || (paddr == ascii_pkg::OFS_IRQ_STAT);
    wire go_wr = wr && (paddr == ascii_pkg::OFS_INIT_GO);
    wire [2:0] go_cnt = (pwdata[2:0] == 3'd0 || pwdata[2:0] > 3'd4) ? 3'd4 : pwdata[2:0];
    wire clr_wr = wr && (paddr == ascii_pkg::OFS_IRQ_CLR);
    wire [ascii_pkg::IRQ_W-1:0] ev = {
        link.char_valid && !char_d_r,
        link.status_word_first[ascii_pkg::SW1_IBUF_FULL] && !full_d_r,
        link.status_word_first[ascii_pkg::SW1_INIT_ERR] && !err_d_r
    };
    wire [ascii_pkg::IRQ_W-1:0] irq_nxt = (irq_stat_r & ~(clr_wr ? pwdata[ascii_pkg::IRQ_W-1:0] : '0)) | ev;

    // bus answer, one wait state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            take_r <= 1'b0;
        end else begin
            pready_r <= access;
            pslverr_r <= access && (!mapped || (pwrite && ro_hit));
            take_r <= rd && (paddr == ascii_pkg::OFS_RXDATA);
            if (rd) begin
                prdata_r <= rd_val;
            end
        end
    end

    // software registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                cfg_r[i] <= ascii_pkg::RST_WORD;
            end
            count_r <= 3'd4;
            init_valid_r <= 1'b0;
            ctrl_r <= ascii_pkg::RST_WORD;
            irq_en_r <= '0;
        end else begin
            init_valid_r <= go_wr;
            if (go_wr) begin
                count_r <= go_cnt;
            end
            if (wr && is_cfg) begin
                cfg_r[cfg_idx] <= pwdata[15:0];
            end
            if (wr && paddr == ascii_pkg::OFS_CTRL) begin
                ctrl_r <= pwdata[15:0];
            end
            if (wr && paddr == ascii_pkg::OFS_IRQ_EN) begin
                irq_en_r <= pwdata[ascii_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky events, set wins over clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
            err_d_r <= 1'b0;
            full_d_r <= 1'b0;
            char_d_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_nxt;
            irq_r <= |(irq_nxt & irq_en_r);
            err_d_r <= link.status_word_first[ascii_pkg::SW1_INIT_ERR];
            full_d_r <= link.status_word_first[ascii_pkg::SW1_IBUF_FULL];
            char_d_r <= link.char_valid;
        end
    end

    assign link.init_valid = init_valid_r;
    assign link.init_count = count_r;
    assign link.cfg_word = cfg_r;
    assign link.control_word_first = ctrl_r;
    assign link.char_take = take_r;
    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
endmodule // ascii_ctl_end

/* File: ascii_link_checker.sv */
// assertions on the link between the controller end and the device end
`timescale 1ns/100ps
module ascii_link_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic init_valid,
    input wire logic [2:0] init_count,
    input wire logic [15:0] cfg_word [4],
    input wire logic [15:0] control_word_first,
    input wire logic char_take,
    input wire logic char_valid,
    input wire logic [7:0] char_data,
    input wire logic [15:0] status_word_first,
    input wire logic [15:0] string_count_status
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire logic [2:0] op_mode = cfg_word[0][4:2];
    wire logic [2:0] tx_mode = cfg_word[0][7:5];
    wire logic [6:0] end_delim = cfg_word[2][14:8];
    wire logic [6:0] fill_delim = cfg_word[3][14:8];
    wire logic err_bit = status_word_first[10];
    property p_op_err; init_valid && op_mode > 3'h1 |-> ##2 err_bit; endproperty
    a_op_err: assert property (p_op_err) else $error("bad op mode not flagged");
    property p_tx_err; init_valid && tx_mode > 3'h5 |-> ##2 err_bit; endproperty
    a_tx_err: assert property (p_tx_err) else $error("bad tx mode not flagged");
    property p_ok; init_valid && init_count == 3'h1 && op_mode <= 3'h1 && tx_mode <= 3'h5 |-> ##2 !err_bit;
    endproperty
    a_ok: assert property (p_ok) else $error("valid init flagged");
    property p_hold; err_bit && !init_valid && !$past(init_valid) |=> err_bit; endproperty
    a_hold: assert property (p_hold) else $error("init error dropped");
    property p_eos_def; init_valid && init_count == 3'h3 && end_delim == 7'h3a |-> ##2 err_bit; endproperty
    a_eos_def: assert property (p_eos_def) else $error("default delimiter clash missed");
    property p_eos_eq; init_valid && init_count == 3'h4 && end_delim == fill_delim |-> ##2 err_bit; endproperty
    a_eos_eq: assert property (p_eos_eq) else $error("delimiter clash missed");
    property p_fill0; init_valid && init_count == 3'h4 && fill_delim == 7'h00 |-> ##2 err_bit; endproperty
    a_fill0: assert property (p_fill0) else $error("zero delimiter missed");
    property p_code; err_bit |-> status_word_first[11:8] == 4'h4; endproperty
    a_code: assert property (p_code) else $error("error code not X4XX");
    property p_bcd;
        string_count_status[3:0] < 4'ha && string_count_status[7:4] < 4'ha
        && string_count_status[11:8] < 4'ha && string_count_status[15:12] < 4'ha;
    endproperty
    a_bcd: assert property (p_bcd) else $error("count not bcd");
    c_err: cover property (init_valid ##2 err_bit);
    c_full: cover property (status_word_first[3] && char_take);
    c_pop: cover property (char_valid && char_take);
endmodule // ascii_link_checker

/* File: tb_top.sv */
// self-checking bench: both ends joined over the link, apb and serial side driven
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module tb_top;
    logic clk_sys = 1'b0, arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, slv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
    logic rxd_pin = 1'b0, rx_char_valid = 1'b0, use_ctrl_lines = 1'b0, hw_fault = 1'b0;
    logic [7:0] rx_char = 8'h00;
    logic [6:0] strings_per_xfer = 7'h00, words_per_string = 7'h00;
    logic stop_send, char_dropped, led_fault, led_buffer_full, led_channel_active;
    logic [1:0] parity_sel;
    logic [15:0] c1, c2, c3, c4;
    logic [6:0] d3, d4;
    logic [2:0] n, en;
    logic [7:0] q[$];
    int err_total = 0, n_compared = 0, drops = 0, m_err = 0, m_prev, i, k, sel;
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (char_dropped === 1'b1) drops <= drops + 1;
    ascii_link_if link (.clk_sys(clk_sys), .arst_n(arst_n));
    ascii_ctl_end ascii_ctl_end_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq));
    ascii_dev_end ascii_dev_end_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .rxd_pin(rxd_pin),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .use_ctrl_lines(use_ctrl_lines),
        .hw_fault(hw_fault), .strings_per_xfer(strings_per_xfer), .words_per_string(words_per_string),
        .stop_send(stop_send), .parity_sel(parity_sel), .char_dropped(char_dropped),
        .led_fault(led_fault), .led_buffer_full(led_buffer_full), .led_channel_active(led_channel_active));
    ascii_link_checker ascii_link_checker_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .init_valid(link.init_valid), .init_count(link.init_count), .cfg_word(link.cfg_word),
        .control_word_first(link.control_word_first), .char_take(link.char_take),
        .char_valid(link.char_valid), .char_data(link.char_data),
        .status_word_first(link.status_word_first), .string_count_status(link.string_count_status));
    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction
    task automatic wait_n(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic init_run;
        apb(1'b1, 8'h28, 32'h0000_0007);
        apb(1'b1, 8'h2c, {29'h0, en});
        apb(1'b1, 8'h00, {16'h0000, c1});
        apb(1'b1, 8'h04, {16'h0000, c2});
        apb(1'b1, 8'h08, {16'h0000, c3});
        apb(1'b1, 8'h0c, {16'h0000, c4});
        apb(1'b1, 8'h10, {29'h0, n});
        wait_n(4);
        m_prev = m_err;
        m_err = (c1[4:2] > 1) || (c1[7:5] > 5) || (n == 3 && c3[14:8] == 7'h3a)
            || (n == 4 && (c3[14:8] == c4[14:8] || c4[14:8] == 7'h00));
        apb(1'b0, 8'h18, 32'h0);
        `CHK(rd[11:8], (m_err != 0 ? 4'h4 : 4'h0))
        `CHK(parity_sel, c1[13:12])
        apb(1'b0, 8'h24, 32'h0);
        `CHK(rd[0], (m_err != 0 && m_prev == 0))
        `CHK(irq, (m_err != 0 && m_prev == 0 && en[0]))
        if (m_err == 0) begin
            apb(1'b0, 8'h1c, 32'h0);
            `CHK(rd[15:0], {(n >= 2 && c2[15]) ? bcd(strings_per_xfer) : 8'h00, bcd(words_per_string)})
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        test_done;
    end
    initial begin
        i = $urandom(32'h80d5);
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        `CHK(led_fault, 1'b0)
        hw_fault <= 1'b1;
        wait_n(4);
        `CHK(led_fault, 1'b1)
        hw_fault <= 1'b0;
        apb(1'b0, 8'h30, 32'h0);
        `CHK(slv, 1'b1)
        apb(1'b1, 8'h18, 32'h0000_ffff);
        `CHK(slv, 1'b1)
        for (i = 0; i < 24; i++) begin
            v = $urandom;
            n = 3'(1 + i % 4);
            sel = (i / 4) % 4;
            d3 = sel == 0 ? 7'h3a : (sel == 1 ? 7'h00 : v[6:0]);
            d4 = sel == 2 ? d3 : (sel == 3 ? 7'h00 : v[13:7]);
            c1 = {2'b00, v[15:14], 4'h0, 3'($urandom % 7), 3'($urandom % 3), 2'b00};
            c2 = {v[16], 15'h0000};
            c3 = {1'b0, d3, 8'h00};
            c4 = {1'b0, d4, 8'h00};
            en = v[19:17];
            strings_per_xfer <= 7'($urandom % 100);
            words_per_string <= 7'($urandom % 100);
            init_run;
        end
        c1 = 16'h0000;
        n = 3'h1;
        en = 3'h0;
        init_run;
        for (k = 0; k < 2; k++) begin
            use_ctrl_lines <= k[0];
            i = drops;
            for (int j = 0; j < 9; j++) begin
                v = $urandom;
                @(posedge clk_sys);
                if (j == 8) begin
                    rx_char_valid <= 1'b0;
                    @(posedge clk_sys);
                end
                rx_char_valid <= (j < 8) || !(k[0] && stop_send);
                rx_char <= v[7:0];
                if (j < 8) q.push_back(v[7:0]);
            end
            @(posedge clk_sys);
            rx_char_valid <= 1'b0;
            wait_n(4);
            `CHK(led_buffer_full, 1'b1)
            `CHK(stop_send, k[0])
            `CHK(drops - i, 1 - k)
            apb(1'b1, 8'h14, 32'h0000_0008);
            apb(1'b0, 8'h18, 32'h0);
            `CHK(rd[3:0], 4'he)
            repeat (8) begin
                apb(1'b0, 8'h20, 32'h0);
                `CHK(rd[8:0], {1'b1, q.pop_front()})
            end
            apb(1'b0, 8'h20, 32'h0);
            `CHK(rd[8], 1'b0)
            wait_n(4);
            `CHK(led_buffer_full, 1'b0)
            `CHK(stop_send, 1'b0)
            apb(1'b1, 8'h14, 32'h0);
        end
        rxd_pin <= 1'b1;
        wait_n(6);
        `CHK(led_channel_active, 1'b1)
        apb(1'b0, 8'h18, 32'h0);
        `CHK(rd[15], 1'b1)
        c1 = 16'h0040;
        init_run;
        `CHK(led_channel_active, 1'b0)
        @(posedge clk_sys);
        rx_char_valid <= 1'b1;
        @(posedge clk_sys);
        rx_char_valid <= 1'b0;
        wait_n(3);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(rd[8], 1'b0)
        test_done;
    end
endmodule // tb_top
